// ### core/lcr_pkg.sv
package lcr_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  // Register offsets
  localparam logic [7:0] OFS_OUTA_IDLE = 8'h2B;
  localparam logic [7:0] OFS_IN_EQ = 8'h2C;
  localparam logic [7:0] OFS_OUTA_SWING1 = 8'h2D;
  localparam logic [7:0] OFS_OUTA_SWING2 = 8'h2E;
  localparam logic [7:0] OFS_IN_IDLE_THR = 8'h2F;
  localparam logic [7:0] OFS_OUTB_IDLE = 8'h32;

  // Reset values
  localparam logic [7:0] RST_OUTA_IDLE = 8'h00;
  localparam logic [7:0] RST_IN_EQ = 8'h20;
  localparam logic [7:0] RST_OUTA_SWING1 = 8'h03;
  localparam logic [7:0] RST_OUTA_SWING2 = 8'h03;
  localparam logic [7:0] RST_IN_IDLE_THR = 8'h00;
  localparam logic [7:0] RST_OUTB_IDLE = 8'h00;

  // Writable bit masks, reserved bits stay zero
  localparam logic [7:0] MSK_IDLE = 8'h30;
  localparam logic [7:0] MSK_EQ = 8'h3F;
  localparam logic [7:0] MSK_SWING1 = 8'h7F;
  localparam logic [7:0] MSK_SWING2 = 8'hFF;
  localparam logic [7:0] MSK_THR = 8'h0F;

  // Field positions
  localparam int POS_IDLE_AUTO = 5;
  localparam int POS_IDLE_FORCE = 4;
  localparam int POS_EQ_EN = 5;

  // Equalizer codes
  localparam logic [5:0] EQ_BYPASS = 6'h20;
  localparam logic [5:0] EQ_LOW = 6'h2A;
  localparam logic [5:0] EQ_MID = 6'h30;
  localparam logic [5:0] EQ_MAX = 6'h3D;

  localparam int NUM_REGS = 6;

  typedef struct packed {
    logic en;
    logic [1:0] gain_stage;
    logic [2:0] boost_level;
  } lcr_eq_s;

  typedef struct packed {
    logic [3:0] swing_type;
    logic [3:0] level_ctrl;
  } lcr_swing2_s;

  typedef struct packed {
    logic [1:0] deassert_sel;
    logic [1:0] assert_sel;
  } lcr_thr_s;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } lcr_req_s;

endpackage

// ### core/lcr_reg_cell.sv
`timescale 1ns/1ps
module lcr_reg_cell
  import lcr_pkg::*;
#(
  parameter logic [7:0] RST_VAL = 8'h00,
  parameter logic [7:0] WR_MASK = 8'hFF
)(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Write port
  input wire logic we,
  input wire logic [7:0] wdata,
  // Stored value
  output logic [7:0] value_q
);

  logic [7:0] value_d;

  // Reserved bits masked off
  assign value_d = we ? (wdata & WR_MASK) : value_q;

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      value_q <= RST_VAL;
    else
      value_q <= value_d;
  end

endmodule

// ### core/lcr_regs.sv
`timescale 1ns/1ps
module lcr_regs
  import lcr_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Management access
  input wire lcr_req_s req,
  output logic [7:0] rdata_q,
  output logic rvalid_q,
  output logic hit_q,
  // Equalizer controls
  output lcr_eq_s eq_ctrl_q,
  output logic eq_boost_active_q,
  output logic [4:0] eq_level_q,
  // Output A and B drive
  output logic [6:0] swing_primary_q,
  output lcr_swing2_s swing_secondary_q,
  output logic outa_mute_q,
  output logic outa_auto_idle_q,
  output logic outa_signal_detect_en_q,
  output logic outb_mute_q,
  output logic outb_auto_idle_q,
  // Idle thresholds
  output lcr_thr_s idle_thr_q
);

  logic [7:0] reg_q [NUM_REGS];
  logic [NUM_REGS-1:0] sel;
  logic [7:0] rd_mux;
  logic any_hit;

  localparam logic [7:0] OFS [NUM_REGS] = '{OFS_OUTA_IDLE, OFS_IN_EQ,
    OFS_OUTA_SWING1, OFS_OUTA_SWING2, OFS_IN_IDLE_THR, OFS_OUTB_IDLE};
  localparam logic [7:0] RSTV [NUM_REGS] = '{RST_OUTA_IDLE, RST_IN_EQ,
    RST_OUTA_SWING1, RST_OUTA_SWING2, RST_IN_IDLE_THR, RST_OUTB_IDLE};
  localparam logic [7:0] MSKV [NUM_REGS] = '{MSK_IDLE, MSK_EQ,
    MSK_SWING1, MSK_SWING2, MSK_THR, MSK_IDLE};

  // Boost ranking of a known equalizer code, 0 for bypass/unknown
  function automatic logic [4:0] eq_rank(input logic [5:0] c);
    unique case (c)
      6'h2A: eq_rank = 5'h01;
      6'h30: eq_rank = 5'h02;
      6'h32: eq_rank = 5'h03;
      6'h39: eq_rank = 5'h04;
      6'h35: eq_rank = 5'h05;
      6'h37: eq_rank = 5'h06;
      6'h3B: eq_rank = 5'h07;
      6'h3D: eq_rank = 5'h08;
      default: eq_rank = 5'h00;
    endcase
  endfunction

  // Register cells
  genvar gi;
  generate
    for (gi = 0; gi < NUM_REGS; gi++)
    begin : g_reg
      assign sel[gi] = (req.addr == OFS[gi]);
      lcr_reg_cell #(.RST_VAL(RSTV[gi]), .WR_MASK(MSKV[gi])) u_cell (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .we(req.wr && sel[gi]),
        .wdata(req.wdata),
        .value_q(reg_q[gi])
      );
    end
  endgenerate

  assign any_hit = |sel;

  always_comb
  begin
    rd_mux = 8'h00;
    for (int i = 0; i < NUM_REGS; i++)
      if (sel[i])
        rd_mux = reg_q[i];
  end

  wire [5:0] eq_f = reg_q[1][5:0];
  wire [6:0] sw1_f = reg_q[2][6:0];
  wire [7:0] sw2_f = reg_q[3];
  wire [3:0] thr_f = reg_q[4][3:0];
  wire a_auto = reg_q[0][POS_IDLE_AUTO];
  wire a_force = reg_q[0][POS_IDLE_FORCE];
  wire b_auto = reg_q[5][POS_IDLE_AUTO];
  wire b_force = reg_q[5][POS_IDLE_FORCE];

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
      hit_q <= 1'b0;
      eq_ctrl_q <= lcr_eq_s'(RST_IN_EQ[5:0]);
      eq_boost_active_q <= 1'b0;
      eq_level_q <= 5'h00;
      swing_primary_q <= RST_OUTA_SWING1[6:0];
      swing_secondary_q <= lcr_swing2_s'(RST_OUTA_SWING2);
      outa_mute_q <= 1'b0;
      outa_auto_idle_q <= 1'b0;
      outa_signal_detect_en_q <= 1'b0;
      outb_mute_q <= 1'b0;
      outb_auto_idle_q <= 1'b0;
      idle_thr_q <= lcr_thr_s'(RST_IN_IDLE_THR[3:0]);
    end
    else
    begin
      rdata_q <= req.rd ? rd_mux : rdata_q;
      rvalid_q <= req.rd;
      hit_q <= req.rd ? any_hit : hit_q;
      eq_ctrl_q <= lcr_eq_s'(eq_f);
      eq_boost_active_q <= eq_f[POS_EQ_EN] && (eq_f != EQ_BYPASS);
      eq_level_q <= eq_rank(eq_f);
      swing_primary_q <= sw1_f;
      swing_secondary_q <= lcr_swing2_s'(sw2_f);
      outa_mute_q <= !a_auto && a_force;
      outa_auto_idle_q <= a_auto;
      outa_signal_detect_en_q <= a_auto || a_force;
      outb_mute_q <= !b_auto && b_force;
      outb_auto_idle_q <= b_auto;
      idle_thr_q <= lcr_thr_s'(thr_f);
    end
  end

  // Assertions
  a_mute_follows_force: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    req.wr && req.addr == OFS_OUTA_IDLE && req.wdata[5:4] == 2'b01
    |=> ##1 outa_mute_q) else $error("mute not set by force");
  a_sd_disabled: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    req.wr && req.addr == OFS_OUTA_IDLE && req.wdata[5:4] == 2'b00
    |=> ##1 !outa_signal_detect_en_q && !outa_mute_q)
    else $error("output A not active with detect off");
  a_idle_reset: assert property (@(posedge clk_sys)
    !rst_n |=> rst_n |-> !outa_mute_q && !outb_mute_q)
    else $error("mute set after reset");
  a_auto_blocks_force: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    req.wr && req.addr == OFS_OUTA_IDLE && req.wdata[5]
    |=> ##1 !outa_mute_q && outa_auto_idle_q)
    else $error("auto idle not overriding");
  a_outb_force_mute: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    req.wr && req.addr == OFS_OUTB_IDLE && req.wdata[5:4] == 2'b01
    |=> ##1 outb_mute_q && !outb_auto_idle_q)
    else $error("output B mute not set");
  a_eq_field_map: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    req.wr && req.addr == OFS_IN_EQ
    |=> ##1 eq_ctrl_q == lcr_eq_s'($past(req.wdata[5:0], 2)))
    else $error("eq field mismatch");
  a_eq_reset_val: assert property (@(posedge clk_sys)
    !rst_n |=> rst_n |-> eq_ctrl_q == lcr_eq_s'(EQ_BYPASS))
    else $error("eq reset not bypass");
  a_eq_bypass_flat: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    req.wr && req.addr == OFS_IN_EQ && req.wdata[5:0] == EQ_BYPASS
    |=> ##1 !eq_boost_active_q && eq_level_q == 5'h00)
    else $error("bypass shows boost");
  a_eq_max_rank: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    req.wr && req.addr == OFS_IN_EQ && req.wdata[5:0] == EQ_MAX
    |=> ##1 eq_level_q == 5'h08) else $error("max boost rank wrong");
  a_eq_low_rank: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    req.wr && req.addr == OFS_IN_EQ && req.wdata[5:0] == EQ_LOW
    |=> ##1 eq_level_q == 5'h01 && eq_boost_active_q)
    else $error("low boost rank wrong");
  a_eq_mid_rank: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    req.wr && req.addr == OFS_IN_EQ && req.wdata[5:0] == EQ_MID
    |=> ##1 eq_level_q == 5'h02 && eq_boost_active_q)
    else $error("mid boost rank wrong");
  a_swing1_width: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    req.wr && req.addr == OFS_OUTA_SWING1
    |=> ##1 swing_primary_q == $past(req.wdata[6:0], 2))
    else $error("primary swing mismatch");
  a_swing2_full: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    req.wr && req.addr == OFS_OUTA_SWING2
    |=> ##1 swing_secondary_q == lcr_swing2_s'($past(req.wdata, 2)))
    else $error("secondary swing mismatch");
  a_swing_reset: assert property (@(posedge clk_sys)
    !rst_n |=> rst_n |-> swing_primary_q == RST_OUTA_SWING1[6:0]
    && swing_secondary_q == lcr_swing2_s'(RST_OUTA_SWING2))
    else $error("swing reset wrong");
  a_thr_split: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    req.wr && req.addr == OFS_IN_IDLE_THR
    |=> ##1 idle_thr_q.deassert_sel == $past(req.wdata[3:2], 2))
    else $error("threshold split wrong");
  a_thr_assert_sel: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    req.wr && req.addr == OFS_IN_IDLE_THR
    |=> ##1 idle_thr_q.assert_sel == $past(req.wdata[1:0], 2))
    else $error("assert threshold wrong");
  a_thr_reset: assert property (@(posedge clk_sys)
    !rst_n |=> rst_n |-> idle_thr_q == 4'h0)
    else $error("threshold reset not zero");
  a_readback: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    req.wr && req.addr == OFS_OUTA_SWING2 ##1 req.rd
    && req.addr == OFS_OUTA_SWING2 && !req.wr
    |=> rdata_q == $past(req.wdata, 2))
    else $error("readback mismatch");
  a_rvalid_pulse: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    req.rd |=> rvalid_q) else $error("read valid missing");
  a_rvalid_drop: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    !req.rd |=> !rvalid_q) else $error("read valid without read");
  a_rdata_hold: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    !req.rd |=> $stable(rdata_q)) else $error("read data not held");
  a_unmapped_read: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    req.rd && (req.addr < OFS_OUTA_IDLE || req.addr > OFS_OUTB_IDLE)
    |=> !hit_q && rdata_q == 8'h00)
    else $error("unmapped read not empty");
  a_mapped_hit: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    req.rd && req.addr == OFS_IN_EQ |=> hit_q)
    else $error("mapped read without hit");

endmodule

// ### dv/lcr_host_model.sv
`timescale 1ns/1ps
module lcr_host_model
  import lcr_pkg::*;
(
  // Clock
  input wire logic clk_sys,
  // Request and answer
  output lcr_req_s req,
  input wire logic [7:0] rdata_q,
  input wire logic rvalid_q
);
  initial req = '{1'b0, 1'b0, 8'hFF, 8'hFF};
  task automatic wr(input logic [7:0] a, d, m);
    @(posedge clk_sys);
    #1;
    req = '{1'b1, 1'b0, a, d & m};
    @(posedge clk_sys);
    #1;
    req = '{1'b0, 1'b0, ~a, ~(d & m)};
  endtask
  task automatic wr_rd(input logic [7:0] a, d, output logic [7:0] q);
    @(posedge clk_sys);
    #1;
    req = '{1'b1, 1'b0, a, d};
    @(posedge clk_sys);
    #1;
    req = '{1'b0, 1'b1, a, 8'hA5};
    @(posedge clk_sys);
    #1;
    req = '{1'b0, 1'b0, ~a, 8'h5A};
    q = rdata_q;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(posedge clk_sys);
    #1;
    req = '{1'b0, 1'b1, a, 8'hA5};
    @(posedge clk_sys);
    #1;
    req = '{1'b0, 1'b0, ~a, 8'h5A};
    d = rdata_q;
    v = rvalid_q;
  endtask
endmodule

// ### dv/lcr_regs_tb.sv
`timescale 1ns/1ps
module lcr_regs_tb;
  import lcr_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  lcr_req_s req;
  logic [7:0] rdata_q, rd_v;
  logic rvalid_q, hit_q, eq_boost_active_q, rd_ok;
  lcr_eq_s eq_ctrl_q;
  logic [4:0] eq_level_q;
  logic [6:0] swing_primary_q;
  lcr_swing2_s swing_secondary_q;
  logic outa_mute_q, outa_auto_idle_q, outa_signal_detect_en_q;
  logic outb_mute_q, outb_auto_idle_q;
  lcr_thr_s idle_thr_q;
  int err_total = 0;
  int checked = 0;
  always #2.5 clk_sys = ~clk_sys;
  lcr_regs dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .req(req),
    .rdata_q(rdata_q), .rvalid_q(rvalid_q), .hit_q(hit_q),
    .eq_ctrl_q(eq_ctrl_q), .eq_boost_active_q(eq_boost_active_q),
    .eq_level_q(eq_level_q), .swing_primary_q(swing_primary_q),
    .swing_secondary_q(swing_secondary_q), .outa_mute_q(outa_mute_q),
    .outa_auto_idle_q(outa_auto_idle_q),
    .outa_signal_detect_en_q(outa_signal_detect_en_q),
    .outb_mute_q(outb_mute_q), .outb_auto_idle_q(outb_auto_idle_q),
    .idle_thr_q(idle_thr_q));
  lcr_host_model host_u (.clk_sys(clk_sys), .req(req), .rdata_q(rdata_q),
    .rvalid_q(rvalid_q));
  task automatic chk(input string n, input logic [7:0] s, e);
    checked++;
    if (s !== e)
    begin
      err_total++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic wr_set(input logic [7:0] a, d, m);
    host_u.wr(a, d, m);
    @(posedge clk_sys);
    #1;
  endtask
  task automatic rd_chk(input string n, input logic [7:0] a, e);
    host_u.rd(a, rd_v, rd_ok);
    chk({n, " valid"}, {7'h00, rd_ok}, 8'h01);
    chk(n, rd_v, e);
  endtask
  task automatic t_reset;
    chk("eq", {2'b00, eq_ctrl_q}, 8'h20);
    chk("sw1", {1'b0, swing_primary_q}, 8'h03);
    chk("sw2", swing_secondary_q, 8'h03);
    chk("thr", {4'h0, idle_thr_q}, 8'h00);
    rd_chk("eq rd", OFS_IN_EQ, 8'h20);
    chk("hit eq", {7'h00, hit_q}, 8'h01);
    rd_chk("thr rd", OFS_IN_IDLE_THR, 8'h00);
    rd_chk("none rd", 8'h40, 8'h00);
    chk("hit", {7'h00, hit_q}, 8'h00);
    $display("reset test done");
  endtask
  task automatic t_eq;
    logic [7:0] c [9] = '{8'h20, 8'h2A, 8'h30, 8'h32, 8'h39, 8'h35, 8'h37,
      8'h3B, 8'h3D};
    for (int i = 0; i < 9; i++)
    begin
      wr_set(OFS_IN_EQ, c[i], MSK_EQ);
      chk("eq", {2'b00, eq_ctrl_q}, c[i]);
      chk("rank", {3'h0, eq_level_q}, i[7:0]);
      chk("boost", {7'h00, eq_boost_active_q}, {7'h00, i != 0});
      rd_chk("eq rd", OFS_IN_EQ, c[i]);
    end
    $display("equalizer test done");
  endtask
  task automatic t_swing;
    logic [7:0] c [3] = '{8'h03, 8'h07, 8'h0F};
    for (int i = 0; i < 3; i++)
    begin
      wr_set(OFS_OUTA_SWING1, c[i], MSK_SWING1);
      chk("sw1", {1'b0, swing_primary_q}, c[i]);
    end
    wr_set(OFS_OUTA_SWING2, 8'hA5, MSK_SWING2);
    chk("sw2 type", {4'h0, swing_secondary_q.swing_type}, 8'h0A);
    chk("sw2 lvl", {4'h0, swing_secondary_q.level_ctrl}, 8'h05);
    rd_chk("sw2 rd", OFS_OUTA_SWING2, 8'hA5);
    host_u.wr_rd(OFS_OUTA_SWING2, 8'h3C, rd_v);
    chk("sw2 b2b", rd_v, 8'h3C);
    $display("swing test done");
  endtask
  task automatic t_thr;
    wr_set(OFS_IN_IDLE_THR, 8'h0E, MSK_THR);
    chk("deassert", {6'h00, idle_thr_q.deassert_sel}, 8'h03);
    chk("assert", {6'h00, idle_thr_q.assert_sel}, 8'h02);
    wr_set(OFS_IN_IDLE_THR, 8'h01, MSK_THR);
    chk("thr", {4'h0, idle_thr_q}, 8'h01);
    $display("threshold test done");
  endtask
  task automatic t_idle;
    logic au, fo;
    for (int k = 0; k < 4; k++)
    begin
      au = k[1];
      fo = k[0];
      wr_set(OFS_OUTA_IDLE, {2'b00, au, fo, 4'h0}, MSK_IDLE);
      wr_set(OFS_OUTB_IDLE, {2'b00, au, fo, 4'h0}, MSK_IDLE);
      chk("mute a", {7'h00, outa_mute_q}, {7'h00, !au && fo});
      chk("sd a", {7'h00, outa_signal_detect_en_q}, {7'h00, au || fo});
      chk("auto a", {7'h00, outa_auto_idle_q}, {7'h00, au});
      chk("mute b", {7'h00, outb_mute_q}, {7'h00, !au && fo});
      chk("auto b", {7'h00, outb_auto_idle_q}, {7'h00, au});
      rd_chk("idle rd", OFS_OUTA_IDLE, {2'b00, au, fo, 4'h0});
    end
    $display("idle test done");
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    repeat (3) @(posedge clk_sys);
    #1;
    rst_n = 1'b1;
    t_reset;
    t_eq;
    t_swing;
    t_thr;
    t_idle;
    results;
  end
  initial
  begin
    #20000;
    err_total++;
    results;
  end
endmodule
